// file: rtl/ldc_pkg.sv
/*
 * Shared constants for the four-channel LED dimming controller:
 * timing figures, register indices, field positions and reset values.
 * Assumes a single 250 MHz clock drives every module that imports it.
 */
`default_nettype none

package ldc_pkg;

    // ************************************************************
    // clock and widths
    // ************************************************************
    localparam int CLK_HZ = 250_000_000;
    localparam int NCH    = 4;
    localparam int DUTY_W = 12;
    localparam int LVL_W  = 6;
    localparam int DIV_W  = 10;
    localparam int STEPS  = 4096;

    // ************************************************************
    // dimming frequency and timing
    // ************************************************************
    localparam int PWM_HZ_0 = 220;
    localparam int PWM_HZ_1 = 250;
    localparam int PWM_HZ_2 = 280;
    localparam int PWM_HZ_3 = 330;
    localparam logic [1:0] FREQ_RST = 2'h1;
    // refresh base rate per hertz of pwm: twice 127500 over 250
    localparam int REF_PER_HZ = 127500 * 2 / 250;
    localparam int PHASE_US   = 160;
    // phase step in pwm ticks at the 250 Hz rate, rounded down
    localparam int PHASE_STEPS = PHASE_US * STEPS * PWM_HZ_1 / 1_000_000;
    localparam int SHORT_MS   = 4;
    localparam int HICCUP_MS  = 1;
    localparam int SHORT_CYC_DEF  = SHORT_MS * (CLK_HZ / 1000);
    localparam int HICCUP_CYC_DEF = HICCUP_MS * (CLK_HZ / 1000);

    // ************************************************************
    // register indices and layout
    // ************************************************************
    localparam logic [7:0] IDX_CTRL     = 8'h00;
    localparam logic [7:0] IDX_CH_EN    = 8'h01;
    localparam logic [7:0] IDX_LVL0     = 8'h02;
    localparam logic [7:0] IDX_DUTY0    = 8'h06;
    localparam logic [7:0] IDX_DIV_LO   = 8'h0E;
    localparam logic [7:0] IDX_DIV_HI   = 8'h0F;
    localparam logic [7:0] IDX_ST_LED   = 8'h10;
    localparam logic [7:0] IDX_ST_TEMP  = 8'h11;
    localparam int CTRL_STAGGER = 0;
    localparam int CTRL_FIE     = 1;
    localparam int CTRL_FREQ    = 2;
    localparam int CTRL_SLEW    = 4;
    localparam int CTRL_STH     = 6;
    localparam logic [7:0] CTRL_RST  = 8'h04;
    localparam logic [3:0] CH_EN_RST = 4'hF;
    localparam logic [5:0] LVL_RST   = 6'h3F;
    localparam logic [9:0] DIV_ZERO_READ = 10'h1A9;
    localparam logic [3:0] ADDR_SEL_MAX  = 4'h9;
    // serial pins idle high: their sync stages start there, no false edge
    localparam logic [11:0] SYNC_RST = 12'h003;

    typedef enum logic [0:0] {CH_RUN, CH_HICCUP} ldc_chan_e;
    typedef enum logic [2:0] {S_IDLE, S_DEV, S_IDX, S_WR, S_RD} ldc_i2c_e;

    function automatic logic [8:0] step_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: step_div = 9'(CLK_HZ / (PWM_HZ_0 * STEPS));
            2'h1: step_div = 9'(CLK_HZ / (PWM_HZ_1 * STEPS));
            2'h2: step_div = 9'(CLK_HZ / (PWM_HZ_2 * STEPS));
            2'h3: step_div = 9'(CLK_HZ / (PWM_HZ_3 * STEPS));
        endcase
    endfunction

    function automatic logic [10:0] ref_div(input logic [1:0] sel);
        unique case (sel)
            2'h0: ref_div = 11'(CLK_HZ / (PWM_HZ_0 * REF_PER_HZ));
            2'h1: ref_div = 11'(CLK_HZ / (PWM_HZ_1 * REF_PER_HZ));
            2'h2: ref_div = 11'(CLK_HZ / (PWM_HZ_2 * REF_PER_HZ));
            2'h3: ref_div = 11'(CLK_HZ / (PWM_HZ_3 * REF_PER_HZ));
        endcase
    endfunction

endpackage

`default_nettype wire

// file: rtl/ldc_reg_if.sv
/*
 * Register access path between the serial slave and the register file.
 * Assumes wr is a one-cycle strobe and rdata follows idx combinationally.
 */
`default_nettype none

interface ldc_reg_if;
    logic       wr;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport slave (output wr, idx, wdata, input rdata);
    modport regs  (input wr, idx, wdata, output rdata);
endinterface

`default_nettype wire

// file: rtl/ldc_i2c_slave.sv
/*
 * Serial register slave: start/stop detection, address match, index
 * byte, auto-incrementing writes and reads.
 * Assumes scl and sda arrive already synchronised and filtered.
 */
`default_nettype none

module ldc_i2c_slave (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [6:0] i_addr,
    ldc_reg_if.slave        reg_if,
    output logic            o_sda_oe
);
    import ldc_pkg::*;

    ldc_i2c_e   st_q, st_d;
    logic [7:0] sh_q, sh_d, idx_q, idx_d, wd_q, wd_d;
    logic [3:0] bit_q, bit_d;
    logic       scl_q, sda_q, rw_q, rw_d, nack_q, nack_d, oe_q, oe_d, wr_q, wr_d;
    logic       start, stop, rise, fall;

    assign start = scl_q & i_scl & sda_q & ~i_sda;
    assign stop  = scl_q & i_scl & ~sda_q & i_sda;
    assign rise  = i_scl & ~scl_q;
    assign fall  = ~i_scl & scl_q;

    // ************************************************************
    // byte engine
    // ************************************************************
    always_comb begin
        st_d = st_q; sh_d = sh_q; idx_d = idx_q; wd_d = wd_q; bit_d = bit_q;
        rw_d = rw_q; nack_d = nack_q; oe_d = oe_q; wr_d = 1'b0;
        if (start) begin
            st_d = S_DEV; bit_d = 4'h0; oe_d = 1'b0;
        end else if (stop) begin
            st_d = S_IDLE; oe_d = 1'b0;
        end else if (st_q != S_IDLE && rise) begin
            if (bit_q < 4'h8 && st_q != S_RD) sh_d = {sh_q[6:0], i_sda};
            if (bit_q == 4'h8) nack_d = i_sda;
            bit_d = bit_q + 4'h1;
        end else if (st_q != S_IDLE && fall) begin
            if (bit_q == 4'h8) begin
                unique case (st_q)
                    S_DEV: begin
                        if (sh_q[7:1] == i_addr) begin
                            oe_d = 1'b1; rw_d = sh_q[0];
                        end else st_d = S_IDLE;
                    end
                    S_IDX: oe_d = 1'b1;
                    S_WR: begin
                        oe_d = 1'b1; wr_d = 1'b1; wd_d = sh_q;
                    end
                    S_RD: begin
                        oe_d = 1'b0; idx_d = idx_q + 8'h1;
                    end
                    S_IDLE: oe_d = 1'b0;
                endcase
            end else if (bit_q == 4'h9) begin
                bit_d = 4'h0; oe_d = 1'b0;
                unique case (st_q)
                    S_DEV: st_d = rw_q ? S_RD : S_IDX;
                    S_IDX: begin
                        idx_d = sh_q; st_d = S_WR;
                    end
                    S_WR: idx_d = idx_q + 8'h1;
                    S_RD: st_d = nack_q ? S_IDLE : S_RD;
                    S_IDLE: st_d = S_IDLE;
                endcase
                if (st_d == S_RD) begin
                    sh_d = reg_if.rdata; oe_d = ~reg_if.rdata[7];
                end
            end else if (st_q == S_RD) begin
                sh_d = {sh_q[6:0], 1'b0}; oe_d = ~sh_q[6];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= S_IDLE; sh_q <= 8'h00; idx_q <= 8'h00; wd_q <= 8'h00;
            bit_q <= 4'h0; rw_q <= 1'b0; nack_q <= 1'b0; oe_q <= 1'b0;
            wr_q <= 1'b0; scl_q <= 1'b1; sda_q <= 1'b1;
        end else if (i_ce) begin
            st_q <= st_d; sh_q <= sh_d; idx_q <= idx_d; wd_q <= wd_d;
            bit_q <= bit_d; rw_q <= rw_d; nack_q <= nack_d; oe_q <= oe_d;
            wr_q <= wr_d; scl_q <= i_scl; sda_q <= i_sda;
        end
    end

    assign reg_if.wr    = wr_q;
    assign reg_if.idx   = wr_q ? idx_q - 8'h0 : idx_q;
    assign reg_if.wdata = wd_q;
    assign o_sda_oe     = oe_q;

endmodule

`default_nettype wire

// file: rtl/ldc_chan.sv
/*
 * One LED channel: duty compare against its phase-shifted count, and the
 * string fault timer with hiccup retry.
 * Assumes fault inputs are synchronised and the count is shared.
 */
`default_nettype none

module ldc_chan #(
    parameter int SHORT_CYC  = ldc_pkg::SHORT_CYC_DEF,
    parameter int HICCUP_CYC = ldc_pkg::HICCUP_CYC_DEF
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic                      i_run,
    input  wire logic [ldc_pkg::DUTY_W-1:0] i_cnt,
    input  wire logic [ldc_pkg::DUTY_W-1:0] i_duty,
    input  wire logic                      i_lvl_nz,
    input  wire logic                      i_short,
    input  wire logic                      i_open,
    output logic                           o_on,
    output logic                           o_short_evt,
    output logic                           o_open_evt
);
    import ldc_pkg::*;

    localparam int TW = $clog2(SHORT_CYC > HICCUP_CYC ? SHORT_CYC : HICCUP_CYC) + 1;

    ldc_chan_e       st_q, st_d;
    logic [TW-1:0]   tmr_q, tmr_d;
    logic            on_d, sev_d, oev_d;

    always_comb begin
        st_d = st_q; tmr_d = tmr_q; sev_d = 1'b0; oev_d = 1'b0;
        unique case (st_q)
            CH_RUN: begin
                if (!i_run || (o_on && !i_short && !i_open)) tmr_d = '0;
                else if (o_on) begin
                    if (tmr_q == TW'(SHORT_CYC - 1)) begin
                        st_d = CH_HICCUP; tmr_d = '0;
                        sev_d = i_short; oev_d = ~i_short;
                    end else tmr_d = tmr_q + 1'b1;
                end
            end
            CH_HICCUP: begin
                if (!i_run || tmr_q == TW'(HICCUP_CYC - 1)) begin
                    st_d = CH_RUN; tmr_d = '0;
                end else tmr_d = tmr_q + 1'b1;
            end
        endcase
        on_d = i_run && st_d == CH_RUN && i_lvl_nz && i_cnt < i_duty;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= CH_RUN; tmr_q <= '0; o_on <= 1'b0;
            o_short_evt <= 1'b0; o_open_evt <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d; tmr_q <= tmr_d; o_on <= on_d;
            o_short_evt <= sev_d; o_open_evt <= oev_d;
        end
    end

endmodule

`default_nettype wire

// file: rtl/ldc_top.sv
/*
 * Four-channel LED dimming controller: register file, pwm time base,
 * phase stagger, refresh/fault pin and fault status.
 * Assumes analog comparators report short/open per channel and an
 * over-temperature level; the current sinks follow O_LED_ON and O_LEVEL.
 */
// Notes on behaviour
// - fault indication off: pin carries the refresh square wave set by divisor
// - fault indication on: pin pulled low while any fault is present
// - each protection event also sets its own sticky status bit
// - enable pin high runs the driver, low turns every channel off
// - low four address bits come from the strap, ten values selectable
// - host enables or disables each channel separately
// - per channel 12-bit duty and 6-bit level act together
// - dimming frequency selectable among 220, 250, 280 and 330 Hz
// - at 250 Hz one duty step lengthens on-time by about 1 us
// - stagger on: each channel rises 163 pwm steps after the previous one, about 160 us at 250 Hz
// - slew field sets rising ramp: 01 about 5 us, 11 about 20 us
// - divisor 0x1A9 at frequency code 01 gives a 300 Hz refresh
// - short declared when pin stays above threshold for 4 ms
// - shorted channel held off 1 ms before retrying
// - frequency codes 00..11 map to 220/250/280/330 Hz, 01 at reset
// - refresh rate is 127500 over divisor times pwm rate over 250
// - zero divisor leaves the pin released high
// - duty takes effect only when its eight high bits are written
`default_nettype none

module ldc_top #(
    parameter int         SHORT_CYC  = ldc_pkg::SHORT_CYC_DEF,
    parameter int         HICCUP_CYC = ldc_pkg::HICCUP_CYC_DEF,
    parameter logic [2:0] ADDR_HI    = 3'h5  // arbitrary value
) (
    input  wire logic                            I_CLOCK,
    input  wire logic                            I_RST,
    input  wire logic                            I_CE,
    input  wire logic                            I_EN,
    input  wire logic                            I_SCL,
    input  wire logic                            I_SDA,
    output logic                                 O_SDA_O,
    output logic                                 O_SDA_OE,
    input  wire logic [3:0]                      I_ADDR_SEL,
    input  wire logic [ldc_pkg::NCH-1:0]         I_SHORT_HI,
    input  wire logic [ldc_pkg::NCH-1:0]         I_OPEN_LO,
    input  wire logic                            I_OTP,
    output logic [ldc_pkg::NCH-1:0]              O_LED_ON,
    output logic [ldc_pkg::NCH*ldc_pkg::LVL_W-1:0] O_LEVEL,
    output logic [1:0]                           O_SLEW,
    output logic [1:0]                           O_SHORT_TH,
    output logic                                 O_RF_O,
    output logic                                 O_RF_OE,
    output logic [ldc_pkg::NCH-1:0]              O_FAULT_SHORT,
    output logic [ldc_pkg::NCH-1:0]              O_FAULT_OPEN,
    output logic                                 O_FAULT_OTP
);
    import ldc_pkg::*;

    localparam int SW = 4 + 2 * NCH;

    ldc_reg_if reg_if ();

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [SW-1:0] s1_q, s2_q, s3_q, flt_q, flt_d;
    logic          en_s, scl_s, sda_s, otp_s;
    logic [NCH-1:0] short_s, open_s;

    // a change counts only once the second and third stages agree
    always_comb flt_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & flt_q);

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            s1_q  <= SW'(SYNC_RST);
            s2_q  <= SW'(SYNC_RST);
            s3_q  <= SW'(SYNC_RST);
            flt_q <= SW'(SYNC_RST);
        end else if (I_CE) begin
            s1_q <= {I_OTP, I_OPEN_LO, I_SHORT_HI, I_EN, I_SDA, I_SCL};
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            flt_q <= flt_d;
        end
    end

    assign {otp_s, open_s, short_s, en_s, sda_s, scl_s} = flt_q;

    // ************************************************************
    // address strap
    // ************************************************************
    logic [3:0] addr_lo_q, addr_lo_d;
    logic       strap_done_q;

    // strap caught after reset, clamped to ten values
    always_comb addr_lo_d = (I_ADDR_SEL > ADDR_SEL_MAX) ? ADDR_SEL_MAX : I_ADDR_SEL;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            addr_lo_q    <= 4'h0;
            strap_done_q <= 1'b0;
        end else if (I_CE && !strap_done_q) begin
            addr_lo_q    <= addr_lo_d;
            strap_done_q <= 1'b1;
        end
    end

    ldc_i2c_slave u_slave (
        .i_clk   (I_CLOCK),
        .i_rst   (I_RST),
        .i_ce    (I_CE),
        .i_scl   (scl_s),
        .i_sda   (sda_s),
        .i_addr  ({ADDR_HI, addr_lo_q}),
        .reg_if  (reg_if.slave),
        .o_sda_oe(O_SDA_OE)
    );

    // ************************************************************
    // register file
    // ************************************************************
    logic [7:0]        ctrl_q, ctrl_d;
    logic [NCH-1:0]    chen_q, chen_d;
    logic [LVL_W-1:0]  lvl_q [NCH], lvl_d [NCH];
    logic [DUTY_W-1:0] duty_q [NCH], duty_d [NCH];
    logic [3:0]        dlo_q [NCH], dlo_d [NCH];
    logic [DIV_W-1:0]  div_q, div_d;
    logic [1:0]        divlo_q, divlo_d;
    logic [NCH-1:0]    sts_q, sts_d, sto_q, sto_d, sev, oev;
    logic              stt_q, stt_d;
    logic [7:0]        rd;
    logic              wr;
    logic [7:0]        wi, wdat;

    assign wr   = reg_if.wr;
    assign wi   = reg_if.idx;
    assign wdat = reg_if.wdata;

    always_comb begin
        ctrl_d = ctrl_q; chen_d = chen_q; div_d = div_q; divlo_d = divlo_q;
        if (wr && wi == IDX_CTRL) ctrl_d = wdat;
        if (wr && wi == IDX_CH_EN) chen_d = wdat[NCH-1:0];
        if (wr && wi == IDX_DIV_LO) divlo_d = wdat[1:0];
        // divisor commits on its high byte
        if (wr && wi == IDX_DIV_HI) div_d = {wdat, divlo_q};
        for (int i = 0; i < NCH; i++) begin
            lvl_d[i] = lvl_q[i]; duty_d[i] = duty_q[i]; dlo_d[i] = dlo_q[i];
            if (wr && wi == IDX_LVL0 + 8'(i)) lvl_d[i] = wdat[LVL_W-1:0];
            if (wr && wi == IDX_DUTY0 + 8'(2 * i)) dlo_d[i] = wdat[3:0];
            // duty moves only on high byte
            if (wr && wi == IDX_DUTY0 + 8'(2 * i + 1)) duty_d[i] = {wdat, dlo_q[i]};
        end
        // events set sticky status, set beats clear
        sts_d = (sts_q & ~((wr && wi == IDX_ST_LED) ? wdat[NCH-1:0] : '0)) | sev;
        sto_d = (sto_q & ~((wr && wi == IDX_ST_LED) ? wdat[7:4] : '0)) | oev;
        stt_d = (stt_q & ~(wr && wi == IDX_ST_TEMP && wdat[0])) | otp_s;
    end

    always_comb begin
        rd = 8'h00;
        if (reg_if.idx == IDX_CTRL) rd = ctrl_q;
        if (reg_if.idx == IDX_CH_EN) rd = {4'h0, chen_q};
        if (reg_if.idx == IDX_DIV_LO) rd = {6'h00, div_q == '0 ? DIV_ZERO_READ[1:0] : div_q[1:0]};
        if (reg_if.idx == IDX_DIV_HI) rd = div_q == '0 ? DIV_ZERO_READ[9:2] : div_q[9:2];
        if (reg_if.idx == IDX_ST_LED) rd = {sto_q, sts_q};
        if (reg_if.idx == IDX_ST_TEMP) rd = {7'h00, stt_q};
        for (int i = 0; i < NCH; i++) begin
            if (reg_if.idx == IDX_LVL0 + 8'(i)) rd = {2'h0, lvl_q[i]};
            if (reg_if.idx == IDX_DUTY0 + 8'(2 * i)) rd = {4'h0, duty_q[i][3:0]};
            if (reg_if.idx == IDX_DUTY0 + 8'(2 * i + 1)) rd = duty_q[i][11:4];
        end
    end

    assign reg_if.rdata = rd;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            ctrl_q  <= CTRL_RST;
            chen_q  <= CH_EN_RST;
            div_q   <= '0;
            divlo_q <= 2'h0;
            sts_q   <= '0;
            sto_q   <= '0;
            stt_q   <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                lvl_q[i] <= LVL_RST; duty_q[i] <= '0; dlo_q[i] <= 4'h0;
            end
        end else if (I_CE) begin
            ctrl_q  <= ctrl_d;
            chen_q  <= chen_d;
            div_q   <= div_d;
            divlo_q <= divlo_d;
            sts_q   <= sts_d;
            sto_q   <= sto_d;
            stt_q   <= stt_d;
            for (int i = 0; i < NCH; i++) begin
                lvl_q[i] <= lvl_d[i]; duty_q[i] <= duty_d[i]; dlo_q[i] <= dlo_d[i];
            end
        end
    end

    // ************************************************************
    // pwm time base
    // ************************************************************
    logic [1:0]        fsel;
    logic [8:0]        step_q, step_d;
    logic [DUTY_W-1:0] pwm_q, pwm_d;
    logic              tick;

    assign fsel = ctrl_q[CTRL_FREQ +: 2];
    assign tick = step_q >= step_div(fsel) - 9'h1;

    always_comb begin
        step_d = tick ? 9'h0 : step_q + 9'h1;
        pwm_d  = tick ? pwm_q + 1'b1 : pwm_q;
        // time base parked while enable pin low
        if (!en_s) begin
            step_d = 9'h0; pwm_d = '0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            step_q <= 9'h0;
            pwm_q  <= '0;
        end else if (I_CE) begin
            step_q <= step_d;
            pwm_q  <= pwm_d;
        end
    end

    // ************************************************************
    // channels
    // ************************************************************
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        logic [DUTY_W-1:0] cnt;
        // stagger each channel by the phase step
        assign cnt = ctrl_q[CTRL_STAGGER] ? pwm_q - DUTY_W'(g * PHASE_STEPS) : pwm_q;

        ldc_chan #(.SHORT_CYC(SHORT_CYC), .HICCUP_CYC(HICCUP_CYC)) u_ch (
            .i_clk      (I_CLOCK),
            .i_rst      (I_RST),
            .i_ce       (I_CE),
            .i_run      (en_s && chen_q[g] && !otp_s),
            .i_cnt      (cnt),
            .i_duty     (duty_q[g]),
            .i_lvl_nz   (lvl_q[g] != '0),
            .i_short    (short_s[g]),
            .i_open     (open_s[g]),
            .o_on       (O_LED_ON[g]),
            .o_short_evt(sev[g]),
            .o_open_evt (oev[g])
        );
        assign O_LEVEL[g*LVL_W +: LVL_W] = lvl_q[g];
    end

    // ************************************************************
    // refresh / fault pin
    // ************************************************************
    logic [10:0]      rstep_q, rstep_d;
    logic [DIV_W-1:0] rcnt_q, rcnt_d;
    logic             rlvl_q, rlvl_d, rf_oe_d, fault;

    // refresh base scales with the pwm rate
    always_comb begin
        rstep_d = rstep_q + 11'h1;
        rcnt_d  = rcnt_q;
        rlvl_d  = rlvl_q;
        if (rstep_q >= ref_div(fsel) - 11'h1) begin
            rstep_d = 11'h0;
            if (rcnt_q >= div_q - 10'h1) begin
                rcnt_d = '0; rlvl_d = ~rlvl_q;
            end else rcnt_d = rcnt_q + 10'h1;
        end
        if (div_q == '0) begin
            rcnt_d = '0; rlvl_d = 1'b1;
        end
        fault = (|sts_q) | (|sto_q) | stt_q | otp_s;
        // square wave, or low on fault
        rf_oe_d = (ctrl_q[CTRL_FIE] && fault) || !rlvl_q;
    end

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            rstep_q <= 11'h0; rcnt_q <= '0; rlvl_q <= 1'b1; O_RF_OE <= 1'b0;
        end else if (I_CE) begin
            rstep_q <= rstep_d; rcnt_q <= rcnt_d; rlvl_q <= rlvl_d; O_RF_OE <= rf_oe_d;
        end
    end

    // slew and threshold codes to the analog side
    assign O_SLEW        = ctrl_q[CTRL_SLEW +: 2];
    assign O_SHORT_TH    = ctrl_q[CTRL_STH +: 2];
    assign O_FAULT_SHORT = sts_q;
    assign O_FAULT_OPEN  = sto_q;
    assign O_FAULT_OTP   = stt_q;
    assign O_RF_O        = 1'b0;
    assign O_SDA_O       = 1'b0;

endmodule

`default_nettype wire

// file: tb/ldc_host.sv
/* Serial host model for the dimming controller.
   Assumes one slave on the bus, strapped to low address bits 3. */
`default_nettype none
module ldc_host (
    input  wire logic i_clk,
    input  wire logic i_dev_oe,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns; timeprecision 1ns;
    // ****
    // open-drain bus
    // ****
    logic drv = 1'b1;
    int   nack = 0;
    initial o_scl = 1'b1;
    assign o_sda = drv & ~i_dev_oe;
    task automatic hold();
        repeat (12) @(negedge i_clk);
    endtask
    // data moves only mid-low phase, never beside the clock edge
    task automatic bit_io(input logic b, output logic s);
        drv = b;
        hold();
        o_scl = 1'b1;
        hold();
        s = o_sda;
        o_scl = 1'b0;
        hold();
    endtask
    task automatic put(input logic [7:0] idx, input logic [7:0] val);
        logic [23:0] w;
        logic        s;
        w = {8'hA6, idx, val};
        drv = 1'b0;
        hold();
        o_scl = 1'b0;
        hold();
        for (int i = 23; i >= 0; i--) begin
            bit_io(w[i], s);
            if (i % 8 == 0) begin
                bit_io(1'b1, s);
                nack += int'(s);
            end
        end
        drv = 1'b0;
        hold();
        o_scl = 1'b1;
        hold();
        drv = 1'b1;
        hold();
    endtask
endmodule
`default_nettype wire

// file: tb/ldc_chk.sv
/* Port checker for the dimming controller.
   Assumes binding to ldc_top with its fault timer parameter. */
`default_nettype none
module ldc_chk
    import ldc_pkg::*;
#(parameter int SHORT_CYC = SHORT_CYC_DEF) (
    input wire logic                 I_CLOCK,
    input wire logic                 I_RST,
    input wire logic                 I_EN,
    input wire logic                 I_OTP,
    input wire logic [NCH-1:0]       I_SHORT_HI,
    input wire logic                 O_SDA_O,
    input wire logic                 O_RF_O,
    input wire logic                 O_RF_OE,
    input wire logic [NCH-1:0]       O_LED_ON,
    input wire logic [NCH*LVL_W-1:0] O_LEVEL,
    input wire logic [NCH-1:0]       O_FAULT_SHORT,
    input wire logic                 O_FAULT_OTP
);
    // ****
    // properties
    // ****
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    sequence s_dark; !O_LED_ON[0] [*8]; endsequence
    property p_sda; O_SDA_O == 1'b0; endproperty
    a_sda: assert property (p_sda) else $error("data pin driven high");
    property p_rf; O_RF_O == 1'b0; endproperty
    a_rf: assert property (p_rf) else $error("fault pin driven high");
    property p_en; !I_EN [*8] |=> O_LED_ON == 4'h0; endproperty
    a_en: assert property (p_en) else $error("led on while disabled");
    property p_otp; I_OTP [*8] |=> O_LED_ON == 4'h0 && O_FAULT_OTP; endproperty
    a_otp: assert property (p_otp) else $error("over-temp not handled");
    property p_hic; $rose(O_FAULT_SHORT[0]) |-> ##2 s_dark; endproperty
    a_hic: assert property (p_hic) else $error("no hiccup off time");
    property p_sht; $rose(O_FAULT_SHORT[0]) |-> $past(I_SHORT_HI[0], SHORT_CYC); endproperty
    a_sht: assert property (p_sht) else $error("short flagged early");
    property p_lvl; O_LED_ON[0] |-> O_LEVEL[5:0] != 0 || $past(O_LEVEL[5:0]) != 0; endproperty
    a_lvl: assert property (p_lvl) else $error("on at zero level");
    property p_rst; $fell(I_RST) |-> O_LED_ON == 4'h0 && !O_RF_OE; endproperty
    a_rst: assert property (p_rst) else $error("bad reset outputs");
endmodule
bind ldc_top ldc_chk #(.SHORT_CYC(SHORT_CYC)) i_ldc_chk (.I_CLOCK, .I_RST, .I_EN, .I_OTP,
    .I_SHORT_HI, .O_SDA_O, .O_RF_O, .O_RF_OE, .O_LED_ON, .O_LEVEL, .O_FAULT_SHORT, .O_FAULT_OTP);
`default_nettype wire

// file: tb/ldc_top_test.sv
/* Self-checking bench for the dimming controller.
   Assumes the host model and the bound checker. */
`default_nettype none
module ldc_top_test;
    import ldc_pkg::*;
    timeunit 1ns; timeprecision 1ns;
    // ****
    // harness
    // ****
    logic       clk = 1'b0, rst = 1'b1, en = 1'b0, otp = 1'b0;
    logic [3:0] shrt = 4'h0;
    wire        scl, sda, sda_oe, rf_oe, f_otp;
    wire  [3:0] led, f_short, f_open, ctl;
    wire [23:0] lvl;
    int         error_cnt = 0, tests_run = 0;
    initial forever #2 clk = ~clk;
    ldc_host i_ldc_host (.i_clk(clk), .i_dev_oe(sda_oe), .o_scl(scl), .o_sda(sda));
    ldc_top #(.SHORT_CYC(50), .HICCUP_CYC(30)) i_ldc_top (.I_CLOCK(clk), .I_RST(rst),
        .I_CE(1'b1), .I_EN(en), .I_SCL(scl), .I_SDA(sda), .O_SDA_O(), .O_SDA_OE(sda_oe),
        .I_ADDR_SEL(4'h3), .I_SHORT_HI(shrt), .I_OPEN_LO(4'h0), .I_OTP(otp), .O_LED_ON(led),
        .O_LEVEL(lvl), .O_SLEW(ctl[3:2]), .O_SHORT_TH(ctl[1:0]), .O_RF_O(), .O_RF_OE(rf_oe),
        .O_FAULT_SHORT(f_short), .O_FAULT_OPEN(f_open), .O_FAULT_OTP(f_otp));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("errors %0d of %0d checks", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // duty near full leaves one dark step a period, so bound covers it
    task automatic wait_on(input logic exp);
        for (int n = 0; n < 20000 && led[0] !== exp; n++) @(negedge clk);
        chk(led[0], exp);
        if (led[0] !== exp) complete_run();
    endtask
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        en = 1'b1;
        repeat (20) @(negedge clk);
        chk(lvl, 24'hFFFFFF);
        i_ldc_host.put(IDX_CTRL, 8'hD6);
        chk(ctl, 4'h7);
        i_ldc_host.put(IDX_LVL0, 8'h15);
        chk(lvl[5:0], 6'h15);
        i_ldc_host.put(IDX_DUTY0, 8'h0F);
        chk(led[0], 1'b0);
        i_ldc_host.put(IDX_DUTY0 + 8'h01, 8'hFF);
        wait_on(1'b1);
        i_ldc_host.put(IDX_CH_EN, 8'h0E);
        wait_on(1'b0);
        i_ldc_host.put(IDX_CH_EN, 8'h0F);
        wait_on(1'b1);
        shrt = 4'h1;
        repeat (100) @(negedge clk);
        chk({f_open, f_short, rf_oe}, 9'h003);
        shrt = 4'h0;
        i_ldc_host.put(IDX_ST_LED, 8'h01);
        chk({f_short, rf_oe}, 5'h00);
        otp = 1'b1;
        repeat (20) @(negedge clk);
        chk({led[0], f_otp, rf_oe}, 3'h3);
        otp = 1'b0;
        en = 1'b0;
        repeat (20) @(negedge clk);
        chk(led, 4'h0);
        chk(i_ldc_host.nack, 0);
        complete_run();
    end
endmodule
`default_nettype wire
